/* File: rtl/scp_ports.sv */
/*
  System control port and CMOS index / NMI mask port, as one I/O slave.
  Assumes a single-cycle I/O strobe from logic on clock_in; board event pins are asynchronous.
*/
// Behaviour
// - the control port answers I/O reads and writes at address 0061.
// - control bit 3 is an active-low channel-check enable, read back, reset to 1.
// - control bit 2 is an active-low parity-check enable, read back, reset to 1.
// - control bit 1 enables speaker data, read back, reset to 0.
// - control bit 0 drives the timer 2 gate and is read back.
// - control read bit 7 is 1 when a parity error has been caught.
// - control read bit 6 is 1 when a channel check error has been caught.
// - control read bit 5 shows the timer 2 output level.
// - control read bit 4 toggles once per refresh request.
// - index port bit 7 masks NMI when 1, bit 6 is reserved.
// - the NMI mask resets to 1 and is write-only.
// - index port bits 5..0 select the CMOS byte moved through port 0071.
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_ports
  import scp_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // I/O bus from the processor
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_rvalid_out,
  // board events (asynchronous)
  input wire logic parity_err_in,
  input wire logic chan_check_in,
  input wire logic timer2_out_in,
  input wire logic refresh_req_in,
  // controls
  output logic timer2_gate_out,
  output logic speaker_en_out,
  output logic nmi_out,
  // CMOS RAM side
  output logic [5:0] cmos_index_out,
  output logic cmos_wr_out,
  output logic cmos_rd_out,
  output logic [7:0] cmos_wdata_out,
  input wire logic [7:0] cmos_rdata_in
);
  // register state
  scp_ctrl_t ctrl_q;
  scp_index_t idx_q;

  // event tracking state
  logic refresh_last_q;
  logic toggle_q;
  logic par_flag_q;
  logic chn_flag_q;

  // synchronised board events
  logic [`SCP_EVENT_COUNT-1:0] sync_w;

  // inputs in bit order: parity, channel, timer2, refresh
  wire [`SCP_EVENT_COUNT-1:0] raw_events = {parity_err_in, chan_check_in, timer2_out_in, refresh_req_in};

  // two flops per pin; only the second stage is read, so metastability stays in the first
  genvar g;
  generate
    for (g = 0; g < `SCP_EVENT_COUNT; g++) begin : g_sync
      logic s1_q;
      logic s2_q;
      always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= raw_events[g];
          s2_q <= s1_q;
        end
      end
      assign sync_w[g] = s2_q;
    end
  endgenerate

  wire par_sync = sync_w[`SCP_EV_PAR];
  wire chn_sync = sync_w[`SCP_EV_CHN];
  wire t2_sync = sync_w[`SCP_EV_T2];
  wire ref_sync = sync_w[`SCP_EV_REF];

  // address decode
  wire sel_ctrl = (io_addr_in == `SCP_ADDR_CTRL);
  wire sel_index = (io_addr_in == `SCP_ADDR_INDEX);
  wire sel_data = (io_addr_in == `SCP_ADDR_DATA);
  wire wr_ctrl = io_wr_in && sel_ctrl;
  wire wr_index = io_wr_in && sel_index;
  wire cmos_wr_hit = io_wr_in && sel_data;
  wire cmos_rd_hit = io_rd_in && sel_data;

  // on the control port only the low four bits are writable; upper write positions are dropped
  wire [`SCP_CTRL_WR_MSB:0] ctrl_wbits = io_wdata_in[`SCP_CTRL_WR_MSB:0];
  wire [`SCP_INDEX_MSB:0] index_wbits = io_wdata_in[`SCP_INDEX_MSB:0];
  wire mask_wbit = io_wdata_in[`SCP_BIT_NMI_MASK];

  // a flag clears only when software writes its enable bit to 1
  wire par_en_written = wr_ctrl && io_wdata_in[`SCP_BIT_PAR_EN_N];
  wire chn_en_written = wr_ctrl && io_wdata_in[`SCP_BIT_CHN_EN_N];

  // set wins over clear so an error in the clearing cycle is kept
  wire par_flag_d = (par_sync && !ctrl_q.par_en_n) || (par_flag_q && !par_en_written);
  wire chn_flag_d = (chn_sync && !ctrl_q.chan_en_n) || (chn_flag_q && !chn_en_written);

  // refresh toggle counts synchronised rising edges only
  wire refresh_edge = ref_sync && !refresh_last_q;
  wire toggle_d = toggle_q ^ refresh_edge;

  // read side of the control port
  wire [7:0] ctrl_rd = {par_flag_q, chn_flag_q, t2_sync, toggle_q, ctrl_q};

  // the index port is write-only; reading it returns zero, not the mask
  wire [7:0] rd_mux = sel_ctrl ? ctrl_rd : (sel_data ? cmos_rdata_in : `SCP_RDATA_IDLE);
  wire [7:0] rdata_d = io_rd_in ? rd_mux : `SCP_RDATA_IDLE;

  // nmi request while any enabled flag is latched and the mask is open
  wire nmi_d = (par_flag_q || chn_flag_q) && !idx_q.nmi_mask;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q <= scp_ctrl_t'(`SCP_CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_q <= scp_ctrl_t'(ctrl_wbits);
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      idx_q <= {`SCP_NMI_MASK_RESET, `SCP_INDEX_RESET};
    end else if (wr_index) begin
      idx_q <= {mask_wbit, index_wbits};
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      refresh_last_q <= 1'b0;
    end else begin
      refresh_last_q <= ref_sync;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      par_flag_q <= 1'b0;
    end else begin
      par_flag_q <= par_flag_d;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      chn_flag_q <= 1'b0;
    end else begin
      chn_flag_q <= chn_flag_d;
    end
  end

  // read data is zero outside a read so a stale byte never leaks onto the bus
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      io_rdata_out <= `SCP_RDATA_IDLE;
    end else begin
      io_rdata_out <= rdata_d;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      io_rvalid_out <= 1'b0;
    end else begin
      io_rvalid_out <= io_rd_in;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      nmi_out <= 1'b0;
    end else begin
      nmi_out <= nmi_d;
    end
  end

  // one-cycle strobes on the CMOS side; the index is steady from the earlier write
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cmos_wr_out <= 1'b0;
    end else begin
      cmos_wr_out <= cmos_wr_hit;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cmos_rd_out <= 1'b0;
    end else begin
      cmos_rd_out <= cmos_rd_hit;
    end
  end

  // write data holds after the strobe so a slow store can take it late
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cmos_wdata_out <= `SCP_RDATA_IDLE;
    end else if (cmos_wr_hit) begin
      cmos_wdata_out <= io_wdata_in;
    end
  end

  // these outputs are flop fields of the register state
  assign timer2_gate_out = ctrl_q.t2_gate;
  assign speaker_en_out = ctrl_q.spk_en;
  assign cmos_index_out = idx_q.index;
endmodule

/* File: shared/scp_pkg.sv */
/*
  Types shared by the system control port logic.
  Assumes scp_regs.svh holds the numeric constants.
*/
package scp_pkg;
  typedef struct packed {
    logic chan_en_n;
    logic par_en_n;
    logic spk_en;
    logic t2_gate;
  } scp_ctrl_t;
  typedef struct packed {
    logic nmi_mask;
    logic [5:0] index;
  } scp_index_t;
endpackage

/* File: shared/scp_regs.svh */
/*
  Port addresses, bit positions and reset values of the system control ports.
  Assumes an 8-bit I/O data path and a 16-bit I/O address.
*/
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
`define SCP_ADDR_CTRL 16'h0061
`define SCP_ADDR_INDEX 16'h0070
`define SCP_ADDR_DATA 16'h0071
`define SCP_BIT_PAR_ERR 7
`define SCP_BIT_CHN_ERR 6
`define SCP_BIT_T2_OUT 5
`define SCP_BIT_REFRESH 4
`define SCP_BIT_CHN_EN_N 3
`define SCP_BIT_PAR_EN_N 2
`define SCP_BIT_SPK_EN 1
`define SCP_BIT_T2_GATE 0
`define SCP_BIT_NMI_MASK 7
`define SCP_CTRL_RESET 4'hC
`define SCP_INDEX_RESET 6'h00
`define SCP_NMI_MASK_RESET 1'h1
`define SCP_CTRL_WR_MSB 3
`define SCP_INDEX_MSB 5
`define SCP_RDATA_IDLE 8'h00
`define SCP_EVENT_COUNT 4
`define SCP_EV_PAR 3
`define SCP_EV_CHN 2
`define SCP_EV_T2 1
`define SCP_EV_REF 0
`endif

/* File: sim/scp_cmos_model.sv */
/* CMOS byte store on the far side
   assumes index and strobes from scp_ports */
`timescale 1ns/1ps
module scp_cmos_model(
  input wire logic clock_in, wr_in,
  input wire logic [5:0] index_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out);
  logic [7:0] mem [64];
  always @(posedge clock_in) if (wr_in) mem[index_in] <= wdata_in;
  assign rdata_out = mem[index_in];
endmodule

/* File: sim/scp_properties.sv */
/* checker on the ports of scp_ports
   assumes one clock domain and the bind below */
`timescale 1ns/1ps
module scp_properties(
  input wire logic clock_in, reset_in, io_wr_in, io_rd_in, io_rvalid_out,
  input wire logic nmi_out, cmos_wr_out, cmos_rd_out, timer2_gate_out, speaker_en_out,
  input wire logic [15:0] io_addr_in,
  input wire logic [7:0] io_wdata_in, io_rdata_out);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  wire w61 = io_wr_in && io_addr_in == 16'h0061;
  property p_rv; io_rd_in |=> io_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_nrv; !io_rd_in |=> !io_rvalid_out; endproperty
  a_nrv: assert property (p_nrv) else $error("stray read valid");
  property p_gate; w61 |=> timer2_gate_out == $past(io_wdata_in[0]); endproperty
  a_gate: assert property (p_gate) else $error("gate not written");
  property p_spk; w61 |=> speaker_en_out == $past(io_wdata_in[1]); endproperty
  a_spk: assert property (p_spk) else $error("speaker not written");
  property p_r70; io_rd_in && io_addr_in == 16'h0070 |=> io_rdata_out == 8'h00; endproperty
  a_r70: assert property (p_r70) else $error("index port readable");
  property p_cw; io_wr_in && io_addr_in == 16'h0071 |=> cmos_wr_out; endproperty
  a_cw: assert property (p_cw) else $error("no cmos write");
  property p_cr; io_rd_in && io_addr_in == 16'h0071 |=> cmos_rd_out; endproperty
  a_cr: assert property (p_cr) else $error("no cmos read");
  property p_msk; io_wr_in && io_addr_in == 16'h0070 && io_wdata_in[7] |-> ##3 !nmi_out; endproperty
  a_msk: assert property (p_msk) else $error("nmi not masked");
  c_nmi: cover property (nmi_out);
  c_crd: cover property (cmos_rd_out);
  c_w61: cover property (w61);
endmodule
bind scp_ports scp_properties u_chk(.*);

/* File: sim/system_control_ports_tb_top.sv */
/* self-checking bench for scp_ports
   assumes the cmos model and checker files */
`timescale 1ns/1ps
`define CHK(x, y) begin comparisons++; if ((x) !== (y)) begin errors++; $display("unexpected %0t %h", $time, x); end end
module system_control_ports_tb_top;
  logic clock_in, reset_in, wr, rd, pe, ce, t2, rf, cw, cr, rv, gate, spk, nmi;
  logic [15:0] a;
  logic [7:0] wd, rdo, cd, crd;
  logic [5:0] ci;
  logic [31:0] r;
  int errors, comparisons, m;
  scp_ports dut(.clock_in(clock_in), .reset_in(reset_in), .io_addr_in(a), .io_wr_in(wr), .io_rd_in(rd),
    .io_wdata_in(wd), .io_rdata_out(rdo), .io_rvalid_out(rv), .parity_err_in(pe), .chan_check_in(ce),
    .timer2_out_in(t2), .refresh_req_in(rf), .timer2_gate_out(gate), .speaker_en_out(spk), .nmi_out(nmi),
    .cmos_index_out(ci), .cmos_wr_out(cw), .cmos_rd_out(cr), .cmos_wdata_out(cd), .cmos_rdata_in(crd));
  scp_cmos_model ram(.clock_in(clock_in), .wr_in(cw), .index_in(ci), .wdata_in(cd), .rdata_out(crd));
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task wr8(input logic [15:0] ad, input logic [7:0] d);
    @(posedge clock_in) begin a <= ad; wd <= d; wr <= 1'b1; end
    @(posedge clock_in) wr <= 1'b0;
  endtask
  task rd8(input logic [15:0] ad, input logic [7:0] e);
    @(posedge clock_in) begin a <= ad; rd <= 1'b1; end
    @(posedge clock_in) rd <= 1'b0;
    #1 `CHK(rv, 1'b1)
    `CHK(rdo, e)
  endtask
  task print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin clock_in = 0; forever #5 clock_in = ~clock_in; end
  initial begin
    {wr, rd, pe, ce, t2, rf} = 0;
    a = 0; wd = 0; r = 32'h8F9A089B; reset_in = 1;
    repeat (12) @(posedge clock_in);
    reset_in <= 0;
    rd8(16'h0061, 8'h0C);
    rd8(16'h0070, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      m = r[3:0];
      wr8(16'h0061, r[7:0]);
      #1 `CHK({spk, gate}, r[1:0])
      rd8(16'h0061, m[7:0]);
      wr8(16'h0070, {2'h2, r[13:8]});
      wr8(16'h0071, r[23:16]);
      wr8(16'h0070, {2'h2, r[13:8]});
      rd8(16'h0071, r[23:16]);
    end
    // enables low and mask open, then every board event at once
    wr8(16'h0061, 8'hF0);
    wr8(16'h0070, 8'h00);
    {pe, ce, t2, rf} <= 4'hF;
    repeat (6) @(posedge clock_in);
    #1 `CHK(nmi, 1'b1)
    rd8(16'h0061, 8'hF0);
    @(posedge clock_in) {pe, ce} <= 2'h0;
    repeat (4) @(posedge clock_in);
    wr8(16'h0061, 8'h0C);
    rd8(16'h0061, 8'h3C);
    `CHK(nmi, 1'b0)
    print_verdict;
  end
endmodule
